//--- src/dmcc_pkg.sv
// shared constants, types and the crc function of the module command path
package dmcc_pkg;
   // ***********************************************************
   // widths and burst shape
   // ***********************************************************
   localparam int DQ_W = 4;
   localparam int ADDR_W = 14;
   localparam int ROW_W = 17;
   localparam int DATA_W = 32;
   localparam int MEM_DEPTH = 16;
   localparam int PH_W = 5;
   localparam logic [4:0] WR_LAT = 5'h04;
   localparam logic [4:0] RD_LAT = 5'h06;
   localparam logic [4:0] BEATS_PLAIN = 5'h08;
   localparam logic [4:0] BEATS_CRC = 5'h0a;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   // ***********************************************************
   // mode register selection and fields
   // ***********************************************************
   localparam logic [2:0] MR_SEL_1 = 3'h1;
   localparam logic [2:0] MR_SEL_2 = 3'h2;
   localparam logic [2:0] MR_SEL_4 = 3'h4;
   localparam logic [2:0] MR_SEL_5 = 3'h5;
   localparam logic [13:0] MR_RESET = 14'h0000;
   localparam int MR1_RTT_LO = 8;
   localparam int MR1_RTT_HI = 10;
   localparam int MR1_TDQS = 11;
   localparam int MR2_CRC = 12;
   localparam int MR4_VREF = 4;
   localparam int MR5_PAR_HI = 2;
   // ***********************************************************
   // command codes on {ras_n, cas_n, we_n} with act_n high
   // ***********************************************************
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_ZQ = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam int AP_BIT = 10;
   // ***********************************************************
   // serial bus device type codes in front of the strap bits
   // ***********************************************************
   localparam logic [3:0] SPD_TYPE = 4'ha;
   localparam logic [3:0] TS_TYPE = 4'h3;

   typedef enum logic [3:0] {
      PWR_ON = 4'b0001,
      PWR_PPD = 4'b0010,
      PWR_APD = 4'b0100,
      PWR_SREF = 4'b1000
   } dmcc_pwr_t;

   typedef enum logic [2:0] {
      OP_MRS = 3'h0,
      OP_REF = 3'h1,
      OP_PRE = 3'h2,
      OP_ACT = 3'h3,
      OP_WR = 3'h4,
      OP_RD = 3'h5,
      OP_ZQ = 3'h6,
      OP_NOP = 3'h7
   } dmcc_op_t;

   function automatic logic [7:0] dmcc_crc8(input logic [31:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = DATA_W - 1; i >= 0; i--)
      begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction : dmcc_crc8
endpackage : dmcc_pkg

//--- src/dmcc_if.sv
// pin bundle between the host controller end and the module end
`timescale 1ns/1ps
`default_nettype none
interface dmcc_if;
   logic cke;
   logic cs_n;
   logic act_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] bg;
   logic [1:0] ba;
   logic [dmcc_pkg::ADDR_W-1:0] addr;
   logic parity;
   logic odt;
   logic reset_n;
   logic [2:0] sa;
   logic [dmcc_pkg::DQ_W-1:0] host_dq_o;
   logic [dmcc_pkg::DQ_W-1:0] host_dq_oe;
   logic [dmcc_pkg::DQ_W-1:0] dev_dq_o;
   logic [dmcc_pkg::DQ_W-1:0] dev_dq_oe;
   logic [dmcc_pkg::DQ_W-1:0] dq;

   // undriven lanes settle high through termination
   assign dq = (dev_dq_oe & dev_dq_o)
      | (~dev_dq_oe & host_dq_oe & host_dq_o)
      | (~dev_dq_oe & ~host_dq_oe);

   modport host (
      output cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr,
      output parity, odt, reset_n, sa, host_dq_o, host_dq_oe,
      input dq
   );
   modport dev (
      input cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr,
      input parity, odt, reset_n, sa, dq,
      output dev_dq_o, dev_dq_oe
   );
endinterface : dmcc_if
`default_nettype wire

//--- src/dmcc_host_end.sv
// host controller end: issues commands and moves burst data
`timescale 1ns/1ps
`default_nettype none
module dmcc_host_end (
   input wire logic mclk, // system clock
   input wire logic rst_n, // async reset, active low
   dmcc_if.host bus, // module pins
   input wire logic cmd_valid, // command request
   output logic cmd_ready, // command can be taken this cycle
   input wire dmcc_pkg::dmcc_op_t cmd_op, // command kind
   input wire logic [1:0] cmd_bg, // bank group
   input wire logic [1:0] cmd_ba, // bank
   input wire logic [16:0] cmd_addr, // row, column or op code
   input wire logic [31:0] wdata, // write burst data
   output logic [31:0] rdata, // read burst data
   output logic rdata_valid, // read data pulse
   output logic rd_crc_err, // read crc mismatch pulse
   input wire logic cke_req, // wanted clock enable level
   input wire logic odt_req, // wanted termination level
   input wire logic ddr_rst_req, // hold the module in reset
   input wire logic [2:0] sa_strap, // serial address straps
   output logic sref_held // memory parked in self refresh
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b01,
      H_DATA = 2'b10
   } dmcc_hst_t;

   dmcc_hst_t hs;
   logic [4:0] ph;
   logic hwr;
   logic [4:0] nb;
   logic par_en;
   logic crc_en;
   logic [39:0] wsh;
   logic [31:0] rbuf;
   logic [7:0] rcrc;
   logic access;
   logic [2:0] rcw;
   logic is_rw;

   assign is_rw = (cmd_op == dmcc_pkg::OP_WR) || (cmd_op == dmcc_pkg::OP_RD);
   assign cmd_ready = (hs == H_IDLE) && bus.cs_n;
   assign access = cmd_valid && cmd_ready;
   assign rcw = (cmd_op == dmcc_pkg::OP_ACT) ? cmd_addr[16:14]
      : 3'(cmd_op);

   // ***********************************************************
   // command pins: one cycle of cs_n low per taken command
   // ***********************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus.cs_n <= 1'b1;
         bus.act_n <= 1'b1;
         {bus.ras_n, bus.cas_n, bus.we_n} <= dmcc_pkg::CMD_NOP;
         bus.bg <= 2'h0;
         bus.ba <= 2'h0;
         bus.addr <= 14'h0000;
         bus.parity <= 1'b0;
      end
      else
      begin
         bus.cs_n <= ~access;
         bus.act_n <= ~(access && cmd_op == dmcc_pkg::OP_ACT);
         {bus.ras_n, bus.cas_n, bus.we_n} <= access ? rcw
            : dmcc_pkg::CMD_NOP;
         bus.bg <= cmd_bg;
         bus.ba <= cmd_ba;
         bus.addr <= cmd_addr[13:0];
         // parity rides the same edge as the command it covers
         bus.parity <= par_en & ^{cmd_op != dmcc_pkg::OP_ACT, rcw,
            cmd_bg, cmd_ba, cmd_addr[13:0]};
      end
   end

   // ***********************************************************
   // level pins
   // ***********************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus.cke <= 1'b0;
         bus.odt <= 1'b0;
         bus.reset_n <= 1'b0;
         bus.sa <= 3'h0;
         sref_held <= 1'b0;
      end
      else
      begin
         // never let clock enable drop under a data burst
         bus.cke <= cke_req | (hs != H_IDLE) | (access && is_rw);
         bus.odt <= odt_req;
         bus.reset_n <= ~ddr_rst_req;
         bus.sa <= sa_strap;
         if (access && cmd_op == dmcc_pkg::OP_REF && !cke_req)
            sref_held <= 1'b1;
         else if (cke_req)
            sref_held <= 1'b0;
      end
   end

   // mirror of our own mode register writes
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         par_en <= 1'b0;
         crc_en <= 1'b0;
      end
      else if (access && cmd_op == dmcc_pkg::OP_MRS)
      begin
         if ({cmd_bg[0], cmd_ba} == dmcc_pkg::MR_SEL_5)
            par_en <= |cmd_addr[dmcc_pkg::MR5_PAR_HI:0];
         if ({cmd_bg[0], cmd_ba} == dmcc_pkg::MR_SEL_2)
            crc_en <= cmd_addr[dmcc_pkg::MR2_CRC];
      end
   end

   // ***********************************************************
   // burst data: phase counts edges from the command sample
   // ***********************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs <= H_IDLE;
         ph <= 5'h00;
         hwr <= 1'b0;
         nb <= dmcc_pkg::BEATS_PLAIN;
         wsh <= 40'h0;
         rbuf <= 32'h0;
         rcrc <= 8'h00;
         rdata <= 32'h0;
         rdata_valid <= 1'b0;
         rd_crc_err <= 1'b0;
         bus.host_dq_o <= 4'h0;
         bus.host_dq_oe <= 4'h0;
      end
      else
      begin
         rdata_valid <= 1'b0;
         rd_crc_err <= 1'b0;
         bus.host_dq_oe <= 4'h0;
         unique case (hs)
            H_IDLE:
            begin
               if (access && is_rw)
               begin
                  hs <= H_DATA;
                  ph <= 5'h00;
                  hwr <= (cmd_op == dmcc_pkg::OP_WR);
                  nb <= crc_en ? dmcc_pkg::BEATS_CRC
                     : dmcc_pkg::BEATS_PLAIN;
                  wsh <= {dmcc_pkg::dmcc_crc8(wdata), wdata};
               end
            end
            H_DATA:
            begin
               ph <= ph + 5'h01;
               if (hwr)
               begin
                  if (ph >= dmcc_pkg::WR_LAT - 5'h01
                     && ph < dmcc_pkg::WR_LAT - 5'h01 + nb)
                  begin
                     bus.host_dq_o <= wsh[3:0];
                     bus.host_dq_oe <= 4'hf;
                     wsh <= {4'h0, wsh[39:4]};
                  end
                  if (ph == dmcc_pkg::WR_LAT - 5'h01 + nb)
                     hs <= H_IDLE;
               end
               else
               begin
                  if (ph >= dmcc_pkg::RD_LAT
                     && ph < dmcc_pkg::RD_LAT + dmcc_pkg::BEATS_PLAIN)
                     rbuf <= {bus.dq, rbuf[31:4]};
                  else if (ph >= dmcc_pkg::RD_LAT + dmcc_pkg::BEATS_PLAIN
                     && ph < dmcc_pkg::RD_LAT + nb)
                     rcrc <= {bus.dq, rcrc[7:4]};
                  if (ph == dmcc_pkg::RD_LAT + nb)
                  begin
                     hs <= H_IDLE;
                     rdata <= rbuf;
                     rdata_valid <= 1'b1;
                     rd_crc_err <= (nb == dmcc_pkg::BEATS_CRC)
                        && (dmcc_pkg::dmcc_crc8(rbuf) != rcrc);
                  end
               end
            end
         endcase
      end
   end
endmodule : dmcc_host_end
`default_nettype wire

//--- src/dmcc_dev_end.sv
// module end: command decode, power states, termination and burst data
`timescale 1ns/1ps
`default_nettype none
module dmcc_dev_end (
   input wire logic mclk, // system clock
   input wire logic rst_n, // async reset, active low
   dmcc_if.dev bus, // module pins
   input wire logic armed, // backup armed, blocks pin reset
   input wire logic vref_cmp, // internal reference comparator level
   output logic mem_rst_n, // effective memory reset, active low
   output dmcc_pkg::dmcc_pwr_t pwr_state, // power state
   output logic clk_run, // internal clocks running
   output logic ca_buf_en, // command/address buffers on
   output logic odt_buf_en, // odt and clock buffers on
   output logic drv_en, // output drivers on
   output logic rtt_on, // termination on data and strobes
   output logic rtt_tdqs_on, // termination on strobe-mirror pins
   output logic par_err, // parity error pulse
   output logic wr_crc_err, // write crc mismatch pulse
   output logic [16:0] row_addr, // row of last activate
   output logic [15:0] open_banks, // banks with an open row
   output logic [6:0] spd_addr, // presence-detect bus address
   output logic [6:0] ts_addr // temperature sensor bus address
);
   logic dev_rst_n;
   logic [2:0] cmd;
   logic par_en;
   logic par_bad;
   logic take;
   logic [3:0] bank;
   logic [13:0] mr1;
   logic [13:0] mr2;
   logic [13:0] mr4;
   logic [13:0] mr5;
   logic [4:0] ph;
   logic dwr;
   logic [4:0] nb;
   logic [3:0] idx;
   logic [31:0] wbuf;
   logic [7:0] wcrc;
   logic [39:0] rsh;
   logic [31:0] mem [0:dmcc_pkg::MEM_DEPTH-1];
   logic [2:0] vref_sync;
   logic vref_lvl;

   // an armed backup keeps the pin from resetting the memory
   assign dev_rst_n = rst_n & (bus.reset_n | armed);
   assign mem_rst_n = dev_rst_n;

   // comparator level is analog: three flops, and a change only counts
   // once the last two agree, so a slow edge cannot flicker on dq0
   always_ff @(posedge mclk or negedge dev_rst_n)
   begin
      if (!dev_rst_n)
      begin
         vref_sync <= 3'h0;
         vref_lvl <= 1'b0;
      end
      else
      begin
         vref_sync <= {vref_sync[1:0], vref_cmp};
         if (vref_sync[1] == vref_sync[2])
            vref_lvl <= vref_sync[2];
      end
   end

   // ***********************************************************
   // input buffers and command qualification
   // ***********************************************************
   // live pin: self refresh exit needs no clock edge to be seen
   assign clk_run = bus.cke;
   assign drv_en = bus.cke;
   assign ca_buf_en = (pwr_state == dmcc_pkg::PWR_ON);
   assign odt_buf_en = (pwr_state != dmcc_pkg::PWR_SREF);
   assign cmd = {bus.ras_n, bus.cas_n, bus.we_n};
   assign bank = {bus.bg, bus.ba};
   assign par_en = |mr5[dmcc_pkg::MR5_PAR_HI:0];
   assign par_bad = par_en & ^{bus.act_n, cmd, bus.bg, bus.ba,
      bus.addr, bus.parity};
   assign take = ca_buf_en & ~bus.cs_n & ~par_bad;

   always_ff @(posedge mclk or negedge dev_rst_n)
   begin
      if (!dev_rst_n)
         par_err <= 1'b0;
      else
         par_err <= ca_buf_en & ~bus.cs_n & par_bad;
   end

   // ***********************************************************
   // power states
   // ***********************************************************
   always_ff @(posedge mclk or negedge dev_rst_n)
   begin
      if (!dev_rst_n)
         pwr_state <= dmcc_pkg::PWR_ON;
      else
      begin
         unique case (pwr_state)
            dmcc_pkg::PWR_ON:
            begin
               if (!bus.cke)
               begin
                  if (take && bus.act_n && cmd == dmcc_pkg::CMD_REF)
                     pwr_state <= dmcc_pkg::PWR_SREF;
                  else if (|open_banks)
                     pwr_state <= dmcc_pkg::PWR_APD;
                  else
                     pwr_state <= dmcc_pkg::PWR_PPD;
               end
            end
            dmcc_pkg::PWR_PPD, dmcc_pkg::PWR_APD, dmcc_pkg::PWR_SREF:
            begin
               if (bus.cke)
                  pwr_state <= dmcc_pkg::PWR_ON;
            end
            default: pwr_state <= dmcc_pkg::PWR_ON;
         endcase
      end
   end

   // ***********************************************************
   // mode registers, banks and rows
   // ***********************************************************
   always_ff @(posedge mclk or negedge dev_rst_n)
   begin
      if (!dev_rst_n)
      begin
         mr1 <= dmcc_pkg::MR_RESET;
         mr2 <= dmcc_pkg::MR_RESET;
         mr4 <= dmcc_pkg::MR_RESET;
         mr5 <= dmcc_pkg::MR_RESET;
      end
      else if (take && bus.cke && bus.act_n && cmd == dmcc_pkg::CMD_MRS)
      begin
         unique case ({bus.bg[0], bus.ba})
            dmcc_pkg::MR_SEL_1: mr1 <= bus.addr;
            dmcc_pkg::MR_SEL_2: mr2 <= bus.addr;
            dmcc_pkg::MR_SEL_4: mr4 <= bus.addr;
            dmcc_pkg::MR_SEL_5: mr5 <= bus.addr;
            default: mr1 <= mr1;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge dev_rst_n)
   begin
      if (!dev_rst_n)
      begin
         open_banks <= 16'h0000;
         row_addr <= 17'h00000;
      end
      else if (take && bus.cke)
      begin
         if (!bus.act_n)
         begin
            open_banks[bank] <= 1'b1;
            row_addr <= {cmd, bus.addr};
         end
         else if (cmd == dmcc_pkg::CMD_PRE)
         begin
            if (bus.addr[dmcc_pkg::AP_BIT])
               open_banks <= 16'h0000;
            else
               open_banks[bank] <= 1'b0;
         end
         else if ((cmd == dmcc_pkg::CMD_WR || cmd == dmcc_pkg::CMD_RD)
            && bus.addr[dmcc_pkg::AP_BIT])
            open_banks[bank] <= 1'b0;
      end
   end

   // ***********************************************************
   // termination and straps
   // ***********************************************************
   always_ff @(posedge mclk or negedge dev_rst_n)
   begin
      if (!dev_rst_n)
      begin
         rtt_on <= 1'b0;
         rtt_tdqs_on <= 1'b0;
      end
      else if (odt_buf_en)
      begin
         // with every termination field zero the pin level is ignored
         rtt_on <= bus.odt
            & (|mr1[dmcc_pkg::MR1_RTT_HI:dmcc_pkg::MR1_RTT_LO]);
         rtt_tdqs_on <= bus.odt & mr1[dmcc_pkg::MR1_TDQS]
            & (|mr1[dmcc_pkg::MR1_RTT_HI:dmcc_pkg::MR1_RTT_LO]);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         spd_addr <= 7'h00;
         ts_addr <= 7'h00;
      end
      else
      begin
         spd_addr <= {dmcc_pkg::SPD_TYPE, bus.sa};
         ts_addr <= {dmcc_pkg::TS_TYPE, bus.sa};
      end
   end

   // ***********************************************************
   // burst data on the four-bit lane
   // ***********************************************************
   // one burst in flight; a second read or write during it is dropped
   always_ff @(posedge mclk or negedge dev_rst_n)
   begin
      if (!dev_rst_n)
      begin
         ph <= 5'h00;
         dwr <= 1'b0;
         nb <= dmcc_pkg::BEATS_PLAIN;
         idx <= 4'h0;
         wbuf <= 32'h0;
         wcrc <= 8'h00;
         rsh <= 40'h0;
         wr_crc_err <= 1'b0;
         bus.dev_dq_o <= 4'h0;
         bus.dev_dq_oe <= 4'h0;
      end
      else
      begin
         wr_crc_err <= 1'b0;
         bus.dev_dq_oe <= 4'h0;
         if (ph == 5'h00)
         begin
            if (take && bus.cke && bus.act_n
               && (cmd == dmcc_pkg::CMD_WR || cmd == dmcc_pkg::CMD_RD))
            begin
               ph <= 5'h01;
               dwr <= (cmd == dmcc_pkg::CMD_WR);
               nb <= mr2[dmcc_pkg::MR2_CRC] ? dmcc_pkg::BEATS_CRC
                  : dmcc_pkg::BEATS_PLAIN;
               idx <= bus.addr[6:3];
               rsh <= {dmcc_pkg::dmcc_crc8(mem[bus.addr[6:3]]),
                  mem[bus.addr[6:3]]};
            end
            else if (mr4[dmcc_pkg::MR4_VREF] && bus.cke)
            begin
               bus.dev_dq_o <= {3'h0, vref_lvl};
               bus.dev_dq_oe <= 4'h1;
            end
         end
         else
         begin
            ph <= ph + 5'h01;
            if (dwr)
            begin
               if (ph >= dmcc_pkg::WR_LAT
                  && ph < dmcc_pkg::WR_LAT + dmcc_pkg::BEATS_PLAIN)
                  wbuf <= {bus.dq, wbuf[31:4]};
               else if (ph >= dmcc_pkg::WR_LAT + dmcc_pkg::BEATS_PLAIN
                  && ph < dmcc_pkg::WR_LAT + nb)
                  wcrc <= {bus.dq, wcrc[7:4]};
               if (ph == dmcc_pkg::WR_LAT + nb)
               begin
                  ph <= 5'h00;
                  wr_crc_err <= (nb == dmcc_pkg::BEATS_CRC)
                     && (dmcc_pkg::dmcc_crc8(wbuf) != wcrc);
               end
            end
            else
            begin
               if (ph >= dmcc_pkg::RD_LAT - 5'h01
                  && ph < dmcc_pkg::RD_LAT - 5'h01 + nb)
               begin
                  bus.dev_dq_o <= rsh[3:0];
                  bus.dev_dq_oe <= {4{bus.cke}};
                  rsh <= {4'h0, rsh[39:4]};
               end
               if (ph == dmcc_pkg::RD_LAT - 5'h01 + nb)
                  ph <= 5'h00;
            end
         end
      end
   end

   // a write with a bad crc leaves the array untouched
   always_ff @(posedge mclk)
   begin
      if (dwr && ph == dmcc_pkg::WR_LAT + nb
         && !(nb == dmcc_pkg::BEATS_CRC
         && dmcc_pkg::dmcc_crc8(wbuf) != wcrc))
         mem[idx] <= wbuf;
   end
endmodule : dmcc_dev_end
`default_nettype wire

//--- dv/dmcc_assertions.sv
// interface checks for the module command path
`timescale 1ns/1ps
`default_nettype none
module dmcc_assertions (
   input wire logic mclk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic cke, // clock enable
   input wire logic cs_n, // chip select
   input wire logic act_n, // activate
   input wire logic ras_n, // row strobe or a16
   input wire logic cas_n, // column strobe or a15
   input wire logic we_n, // write enable or a14
   input wire logic [1:0] bg, // bank group
   input wire logic [1:0] ba, // bank
   input wire logic [dmcc_pkg::ADDR_W-1:0] addr, // address
   input wire logic parity, // parity bit
   input wire logic reset_n, // memory reset
   input wire logic [dmcc_pkg::DQ_W-1:0] host_dq_oe, // host drive
   input wire logic [dmcc_pkg::DQ_W-1:0] dev_dq_oe // device drive
);
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic cmd_wr;
   logic cmd_rd;
   assign cmd_wr = !cs_n && act_n && {ras_n, cas_n, we_n} == dmcc_pkg::CMD_WR;
   assign cmd_rd = !cs_n && act_n && {ras_n, cas_n, we_n} == dmcc_pkg::CMD_RD;
   cs_pulse_a: assert property ($fell(cs_n) |=> cs_n)
      else $error("chip select low too long");
   burst_cke_a: assert property (|host_dq_oe || dev_dq_oe[3] |-> cke)
      else $error("clock enable low in a burst");
   drv_off_a: assert property (!cke |-> dev_dq_oe == '0)
      else $error("device drives with clock enable low");
   no_clash_a: assert property ((host_dq_oe & dev_dq_oe) == '0)
      else $error("both ends drive dq");
   wr_lat_a: assert property (cmd_wr |-> ##[3:4] host_dq_oe == '1)
      else $error("write data late");
   wr_len_a: assert property ($rose(host_dq_oe[3]) |-> host_dq_oe[3][*8]
      ##1 (!host_dq_oe[3] or host_dq_oe[3] [*2] ##1 !host_dq_oe[3]))
      else $error("write burst length wrong");
   rd_lat_a: assert property (cmd_rd && cke |-> ##[5:6] dev_dq_oe[3])
      else $error("read data late");
   rst_hold_a: assert property (|host_dq_oe |-> reset_n)
      else $error("memory reset during a burst");
   par_even_a: assert property (!cs_n |->
      !(^{act_n, ras_n, cas_n, we_n, bg, ba, addr, parity}))
      else $error("command parity odd");
endmodule : dmcc_assertions
`default_nettype wire

//--- dv/tb.sv
// self-checking bench joining the host end and the module end
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 0, rst_n = 0, cmd_valid = 0, cke_req = 1, odt_req = 0;
   logic ddr_rst_req = 0, armed = 0, vref_cmp = 1;
   logic [1:0] cmd_bg = 0, cmd_ba = 0;
   logic [16:0] cmd_addr = 0;
   logic [31:0] wdata = 0;
   logic [2:0] sa_strap = 3'h5;
   dmcc_pkg::dmcc_op_t cmd_op = dmcc_pkg::OP_NOP;
   logic cmd_ready, rdata_valid, rd_crc_err, sref_held, mem_rst_n, clk_run;
   logic ca_buf_en, odt_buf_en, drv_en, rtt_on, rtt_tdqs_on, par_err;
   logic wr_crc_err;
   logic [31:0] rdata;
   logic [16:0] row_addr;
   logic [15:0] open_banks;
   logic [6:0] spd_addr, ts_addr;
   dmcc_pkg::dmcc_pwr_t pwr_state;
   int num_errors = 0, compares = 0, crc_hits = 0;
   // ****************************************
   // structure
   // ****************************************
   dmcc_if bus();
   dmcc_host_end u_dmcc_host_end (.*);
   dmcc_dev_end u_dmcc_dev_end (.*);
   dmcc_assertions u_dmcc_assertions (.mclk, .rst_n, .cke(bus.cke),
      .cs_n(bus.cs_n), .act_n(bus.act_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
      .we_n(bus.we_n), .bg(bus.bg), .ba(bus.ba), .addr(bus.addr),
      .parity(bus.parity), .reset_n(bus.reset_n),
      .host_dq_oe(bus.host_dq_oe), .dev_dq_oe(bus.dev_dq_oe));
   always #4 mclk = ~mclk;
   // only the forced write crc case may pulse, and it is counted
   always @(negedge mclk)
      if (wr_crc_err === 1'b1) crc_hits++;
      else if (rst_n && (par_err | rd_crc_err | wr_crc_err) !== 1'b0)
         bad("pulse");
   // ****************************************
   // tasks
   // ****************************************
   task automatic results;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic bad(input string m);
      num_errors++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) bad("value mismatch");
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic lim(input int i, input int n);
      if (i >= n)
      begin
         bad("timeout");
         results();
      end
   endtask : lim
   // called at a falling edge; ready does not depend on valid
   task automatic cmd(input dmcc_pkg::dmcc_op_t op, input logic [3:0] bb,
      input logic [16:0] a, input logic ck);
      int i;
      for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) @(negedge mclk);
      lim(i, 60);
      cmd_op = op;
      {cmd_bg, cmd_ba} = bb;
      cmd_addr = a;
      cke_req = ck;
      cmd_valid = 1;
      @(negedge mclk);
      cmd_valid = 0;
   endtask : cmd
   task automatic rd(input logic [16:0] a, input logic [31:0] e);
      int i;
      cmd(dmcc_pkg::OP_RD, 4'h0, a, 1'b1);
      for (i = 0; i < 40 && rdata_valid !== 1'b1; i++) @(negedge mclk);
      lim(i, 40);
      chk(rdata, e);
   endtask : rd
   // ****************************************
   // sequence
   // ****************************************
   initial
   begin
      cyc(2);
      rst_n = 1;
      cyc(3);
      chk(spd_addr, {dmcc_pkg::SPD_TYPE, 3'h5});
      chk(ts_addr, {dmcc_pkg::TS_TYPE, 3'h5});
      armed = 1;
      ddr_rst_req = 1;
      cyc(3);
      chk(mem_rst_n, 1'b1);
      armed = 0;
      cyc(1);
      chk(mem_rst_n, 1'b0);
      ddr_rst_req = 0;
      cyc(3);
      $display("test reset done");
      cmd(dmcc_pkg::OP_MRS, {1'b0, dmcc_pkg::MR_SEL_5}, 17'h1, 1'b1);
      odt_req = 1;
      cyc(3);
      chk(rtt_on, 1'b0);
      cmd(dmcc_pkg::OP_MRS, {1'b0, dmcc_pkg::MR_SEL_1}, 17'h900, 1'b1);
      cyc(3);
      chk({rtt_on, rtt_tdqs_on}, 2'h3);
      odt_req = 0;
      cyc(3);
      chk(rtt_on, 1'b0);
      $display("test termination done");
      wdata = 32'h1234abcd;
      cmd(dmcc_pkg::OP_WR, 4'h0, 17'h18, 1'b1);
      rd(17'h18, 32'h1234abcd);
      cmd(dmcc_pkg::OP_MRS, {1'b0, dmcc_pkg::MR_SEL_2}, 17'h1000, 1'b1);
      wdata = 32'h0f5a9c3e;
      cmd(dmcc_pkg::OP_WR, 4'h0, 17'h28, 1'b1);
      rd(17'h28, 32'h0f5a9c3e);
      rd(17'h18, 32'h1234abcd);
      // crc off on the host only: the module waits for two crc beats
      cmd(dmcc_pkg::OP_MRS, {1'b0, dmcc_pkg::MR_SEL_2}, 17'h0, 1'b0);
      cke_req = 1;
      cyc(3);
      wdata = 32'h0;
      cmd(dmcc_pkg::OP_WR, 4'h0, 17'h18, 1'b1);
      cyc(16);
      chk(crc_hits, 1);
      rd(17'h18, 32'h1234abcd);
      cmd(dmcc_pkg::OP_MRS, {1'b0, dmcc_pkg::MR_SEL_2}, 17'h0, 1'b1);
      $display("test data done");
      cmd(dmcc_pkg::OP_ACT, 4'h9, 17'h1c005, 1'b1);
      cyc(2);
      chk(row_addr, 17'h1c005);
      chk(open_banks[9], 1'b1);
      cke_req = 0;
      cyc(3);
      chk(pwr_state, dmcc_pkg::PWR_APD);
      chk({clk_run, drv_en, ca_buf_en, odt_buf_en}, 4'h1);
      cke_req = 1;
      cyc(3);
      chk({pwr_state, clk_run}, {dmcc_pkg::PWR_ON, 1'b1});
      cmd(dmcc_pkg::OP_PRE, 4'h0, 17'h400, 1'b1);
      cke_req = 0;
      cyc(3);
      chk(pwr_state, dmcc_pkg::PWR_PPD);
      cke_req = 1;
      cyc(3);
      cmd(dmcc_pkg::OP_REF, 4'h0, 17'h0, 1'b0);
      cyc(3);
      chk(pwr_state, dmcc_pkg::PWR_SREF);
      chk({odt_buf_en, sref_held}, 2'h1);
      cke_req = 1;
      cyc(2);
      chk(pwr_state, dmcc_pkg::PWR_ON);
      $display("test power done");
      cmd(dmcc_pkg::OP_MRS, {1'b0, dmcc_pkg::MR_SEL_4}, 17'h10, 1'b1);
      vref_cmp = 0;
      cyc(6);
      chk(bus.dq[0], 1'b0);
      vref_cmp = 1;
      cyc(6);
      chk(bus.dq[0], 1'b1);
      $display("test reference done");
      chk(crc_hits, 1);
      results();
   end
endmodule : tb
`default_nettype wire
